/* core/io_space_defs.svh */
`ifndef IO_SPACE_DEFS_SVH
`define IO_SPACE_DEFS_SVH
`define IO_BASE_IN_DATA 10'h020
`define IO_DATA_LAST 10'h05F
`define IO_BIT_LIMIT 6'h20
`define A_SER_BAUD 6'h09
`define A_SER_CTRL 6'h0A
`define A_SER_STAT 6'h0B
`define A_PD_IN 6'h10
`define A_PD_DIR 6'h11
`define A_PD_OUT 6'h12
`define A_PC_OUT 6'h13
`define A_PB_IN 6'h16
`define A_PB_DIR 6'h17
`define A_PB_OUT 6'h18
`define A_PA_IN 6'h19
`define A_PA_DIR 6'h1A
`define A_PA_OUT 6'h1B
`define A_WDT_CTRL 6'h21
`define A_CAP_LO 6'h24
`define A_CAP_HI 6'h25
`define A_CMPB_LO 6'h28
`define A_CMPB_HI 6'h29
`define A_CMPA_LO 6'h2A
`define A_CMPA_HI 6'h2B
`define A_T1_LO 6'h2C
`define A_T1_HI 6'h2D
`define A_T1_CTLB 6'h2E
`define A_T1_CTLA 6'h2F
`define A_T0_CNT 6'h32
`define A_T0_CTRL 6'h33
`define A_MCU_CTRL 6'h35
`define A_TIM_FLAGS 6'h38
`define A_TIM_MASK 6'h39
`define A_EXT_FLAGS 6'h3A
`define A_EXT_MASK 6'h3B
`define A_SP_LO 6'h3D
`define A_SP_HI 6'h3E
`define A_STATUS 6'h3F
`define REG_RESET 8'h00
`endif

/* core/io_space_pkg.sv */
package io_space_pkg;
  // operation issued by the core in one cycle
  typedef enum logic [2:0] {
    OP_NONE,
    OP_IN,
    OP_OUT,
    OP_BIT_SET,
    OP_BIT_CLEAR,
    OP_SKIP_SET,
    OP_SKIP_CLEAR
  } io_op_t;
endpackage

/* core/io_space_register_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
`include "io_space_defs.svh"
module io_space_register_decoder (
  input wire logic CLK_IN, // 20 MHz system clock
  input wire logic RSTN_IN, // async reset, active low
  input wire io_space_pkg::io_op_t OP_IN, // I/O-instruction operation
  input wire logic [5:0] IO_ADDR_IN, // I/O address 0x00..0x3F
  input wire logic [2:0] BIT_SEL_IN, // bit index for bit ops
  input wire logic [7:0] WDATA_IN, // byte from working register
  input wire logic DM_WE_IN, // data-memory write strobe
  input wire logic DM_RE_IN, // data-memory read strobe
  input wire logic [9:0] DM_ADDR_IN, // data-memory address
  input wire logic [7:0] PA_PINS_IN, // port A pins (async)
  input wire logic [7:0] PB_PINS_IN, // port B pins (async)
  input wire logic [7:0] PD_PINS_IN, // port D pins (async)
  input wire logic [7:0] SER_STAT_HW_IN, // serial status from uart
  input wire logic [15:0] CAPTURE_IN, // captured count from timer
  output logic [7:0] RDATA_OUT, // read byte, registered
  output logic DM_HIT_OUT, // data address maps into I/O space
  output logic SKIP_OUT, // skip next instruction, registered
  output logic [7:0] PA_OUT_OUT, // port A output latch
  output logic [7:0] PA_DIR_OUT, // port A direction
  output logic [7:0] PB_OUT_OUT, // port B output latch
  output logic [7:0] PB_DIR_OUT, // port B direction
  output logic [7:0] PC_OUT_OUT, // port C output latch
  output logic [7:0] PD_OUT_OUT, // port D output latch
  output logic [7:0] PD_DIR_OUT, // port D direction
  output logic [7:0] SER_BAUD_OUT, // serial baud divisor
  output logic [7:0] SER_CTRL_OUT, // serial control
  output logic [15:0] CMPA_OUT, // compare A value
  output logic [15:0] CMPB_OUT, // compare B value
  output logic [7:0] STATUS_OUT // status flags
);

  // ************************************************
  // address resolution
  // ************************************************

  // map a data address onto an I/O address by removing the alias offset
  function automatic logic [5:0] dm_to_io(input logic [9:0] a);
    logic [9:0] d;
    d = a - `IO_BASE_IN_DATA;
    return d[5:0];
  endfunction

  logic dm_hit;
  logic [5:0] dm_io;
  logic io_op;
  logic [5:0] addr;
  logic wr_en;
  logic rd_en;
  logic [7:0] wr_byte;
  logic [7:0] cur;

  // usb registers sit far above this window, so they never hit here
  assign dm_hit = (DM_ADDR_IN >= `IO_BASE_IN_DATA) && (DM_ADDR_IN <= `IO_DATA_LAST);
  assign dm_io = dm_to_io(DM_ADDR_IN);
  assign DM_HIT_OUT = dm_hit;
  assign io_op = (OP_IN != io_space_pkg::OP_NONE);
  // instruction path wins; it uses the raw I/O address
  assign addr = io_op ? IO_ADDR_IN : dm_io;

  // ************************************************
  // input synchronisers
  // ************************************************

  logic [7:0] pa_s1_r, pa_s2_r, pb_s1_r, pb_s2_r, pd_s1_r, pd_s2_r;

  // two stages because pins change with no regard to our clock
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      pa_s1_r <= `REG_RESET;
      pa_s2_r <= `REG_RESET;
      pb_s1_r <= `REG_RESET;
      pb_s2_r <= `REG_RESET;
      pd_s1_r <= `REG_RESET;
      pd_s2_r <= `REG_RESET;
    end else begin
      pa_s1_r <= PA_PINS_IN;
      pa_s2_r <= pa_s1_r;
      pb_s1_r <= PB_PINS_IN;
      pb_s2_r <= pb_s1_r;
      pd_s1_r <= PD_PINS_IN;
      pd_s2_r <= pd_s1_r;
    end
  end

  // ************************************************
  // register file
  // ************************************************

  logic [7:0] regs_r [0:63];
  logic [63:0] writable;

  // 1 marks a location that holds a software-written byte
  always_comb begin
    writable = '0;
    writable[`A_SER_BAUD] = 1'b1;
    writable[`A_SER_CTRL] = 1'b1;
    writable[`A_SER_STAT] = 1'b1;
    writable[`A_PD_DIR] = 1'b1;
    writable[`A_PD_OUT] = 1'b1;
    writable[`A_PC_OUT] = 1'b1;
    writable[`A_PB_DIR] = 1'b1;
    writable[`A_PB_OUT] = 1'b1;
    writable[`A_PA_DIR] = 1'b1;
    writable[`A_PA_OUT] = 1'b1;
    writable[`A_WDT_CTRL] = 1'b1;
    writable[`A_CMPB_LO] = 1'b1;
    writable[`A_CMPB_HI] = 1'b1;
    writable[`A_CMPA_LO] = 1'b1;
    writable[`A_CMPA_HI] = 1'b1;
    writable[`A_T1_LO] = 1'b1;
    writable[`A_T1_HI] = 1'b1;
    writable[`A_T1_CTLB] = 1'b1;
    writable[`A_T1_CTLA] = 1'b1;
    writable[`A_T0_CNT] = 1'b1;
    writable[`A_T0_CTRL] = 1'b1;
    writable[`A_MCU_CTRL] = 1'b1;
    writable[`A_TIM_FLAGS] = 1'b1;
    writable[`A_TIM_MASK] = 1'b1;
    writable[`A_EXT_FLAGS] = 1'b1;
    writable[`A_EXT_MASK] = 1'b1;
    writable[`A_SP_LO] = 1'b1;
    writable[`A_SP_HI] = 1'b1;
    writable[`A_STATUS] = 1'b1;
  end

  // combinational view of every location; unassigned ones read zero
  function automatic logic [7:0] view(input logic [5:0] a, input logic [7:0] stored,
                                      input logic [7:0] pa, input logic [7:0] pb,
                                      input logic [7:0] pd, input logic [7:0] sst,
                                      input logic [15:0] cap, input logic wr_ok);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `A_PA_IN: v = pa;
      `A_PB_IN: v = pb;
      `A_PD_IN: v = pd;
      `A_CAP_LO: v = cap[7:0];
      `A_CAP_HI: v = cap[15:8];
      `A_SER_STAT: v = stored | sst;
      default: v = wr_ok ? stored : 8'h00;
    endcase
    return v;
  endfunction

  assign cur = view(addr, regs_r[addr], pa_s2_r, pb_s2_r, pd_s2_r, SER_STAT_HW_IN,
                    CAPTURE_IN, writable[addr]);

  // ************************************************
  // write and bit operations
  // ************************************************

  logic bit_ok;
  assign bit_ok = (addr < `IO_BIT_LIMIT);

  // bit ops are a read-modify-write of one bit; others keep their value
  always_comb begin
    wr_en = 1'b0;
    wr_byte = regs_r[addr];
    case (OP_IN)
      io_space_pkg::OP_OUT: begin
        wr_en = 1'b1;
        wr_byte = WDATA_IN;
      end
      io_space_pkg::OP_BIT_SET: begin
        wr_en = bit_ok;
        wr_byte = regs_r[addr] | (8'h01 << BIT_SEL_IN);
      end
      io_space_pkg::OP_BIT_CLEAR: begin
        wr_en = bit_ok;
        wr_byte = regs_r[addr] & ~(8'h01 << BIT_SEL_IN);
      end
      io_space_pkg::OP_NONE: begin
        wr_en = DM_WE_IN && dm_hit;
        wr_byte = WDATA_IN;
      end
      default: begin
        wr_en = 1'b0;
        wr_byte = regs_r[addr];
      end
    endcase
  end

  // writes to read-only or reserved locations are dropped
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      for (int i = 0; i < 64; i++) begin
        regs_r[i] <= `REG_RESET;
      end
    end else if (wr_en && writable[addr]) begin
      regs_r[addr] <= wr_byte;
    end
  end

  // ************************************************
  // read path and skip test
  // ************************************************

  assign rd_en = (OP_IN == io_space_pkg::OP_IN) || (!io_op && DM_RE_IN && dm_hit);

  logic [7:0] rdata_nxt;
  logic skip_nxt;
  logic [7:0] cur_bit_mask;
  assign cur_bit_mask = 8'h01 << BIT_SEL_IN;

  always_comb begin
    rdata_nxt = rd_en ? cur : 8'h00;
    skip_nxt = 1'b0;
    if (bit_ok && OP_IN == io_space_pkg::OP_SKIP_SET) begin
      skip_nxt = |(cur & cur_bit_mask);
    end else if (bit_ok && OP_IN == io_space_pkg::OP_SKIP_CLEAR) begin
      skip_nxt = ~|(cur & cur_bit_mask);
    end
  end

  // answer is registered one cycle after the request
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      RDATA_OUT <= `REG_RESET;
      SKIP_OUT <= 1'b0;
    end else begin
      RDATA_OUT <= rdata_nxt;
      SKIP_OUT <= skip_nxt;
    end
  end

  // ************************************************
  // peripheral outputs
  // ************************************************

  assign PA_OUT_OUT = regs_r[`A_PA_OUT];
  assign PA_DIR_OUT = regs_r[`A_PA_DIR];
  assign PB_OUT_OUT = regs_r[`A_PB_OUT];
  assign PB_DIR_OUT = regs_r[`A_PB_DIR];
  assign PC_OUT_OUT = regs_r[`A_PC_OUT];
  assign PD_OUT_OUT = regs_r[`A_PD_OUT];
  assign PD_DIR_OUT = regs_r[`A_PD_DIR];
  assign SER_BAUD_OUT = regs_r[`A_SER_BAUD];
  assign SER_CTRL_OUT = regs_r[`A_SER_CTRL];
  assign CMPA_OUT = {regs_r[`A_CMPA_HI], regs_r[`A_CMPA_LO]};
  assign CMPB_OUT = {regs_r[`A_CMPB_HI], regs_r[`A_CMPB_LO]};
  assign STATUS_OUT = regs_r[`A_STATUS];

  // ************************************************
  // assertions
  // ************************************************

  property p_out_store;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    (OP_IN == io_space_pkg::OP_OUT && IO_ADDR_IN == `A_PA_OUT) |=> (PA_OUT_OUT == $past(WDATA_IN));
  endproperty
  a_out_store: assert property (p_out_store) else $error("out lost");

  property p_in_read;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    (OP_IN == io_space_pkg::OP_IN && IO_ADDR_IN == `A_SER_BAUD) |=> (RDATA_OUT == SER_BAUD_OUT);
  endproperty
  a_in_read: assert property (p_in_read) else $error("in wrong");

  property p_alias;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    (OP_IN == io_space_pkg::OP_NONE && DM_WE_IN && DM_ADDR_IN == 10'h03A)
      |=> (PA_DIR_OUT == $past(WDATA_IN));
  endproperty
  a_alias: assert property (p_alias) else $error("alias map wrong");

  property p_bit_high_blocked;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    (OP_IN == io_space_pkg::OP_BIT_SET && IO_ADDR_IN == `A_STATUS) |=> $stable(STATUS_OUT);
  endproperty
  a_bit_high_blocked: assert property (p_bit_high_blocked) else $error("bit op high");

  property p_bit_set;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    (OP_IN == io_space_pkg::OP_BIT_SET && IO_ADDR_IN == `A_PA_OUT)
      |=> (PA_OUT_OUT == ($past(PA_OUT_OUT) | (8'h01 << $past(BIT_SEL_IN))));
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("bit set wrong");

  property p_skip;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    (OP_IN == io_space_pkg::OP_SKIP_SET && IO_ADDR_IN == `A_PA_OUT)
      |=> (SKIP_OUT == $past(PA_OUT_OUT[BIT_SEL_IN]));
  endproperty
  a_skip: assert property (p_skip) else $error("skip wrong");

  property p_cmpa;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    (OP_IN == io_space_pkg::OP_OUT && IO_ADDR_IN == `A_CMPA_HI)
      |=> (CMPA_OUT[15:8] == $past(WDATA_IN));
  endproperty
  a_cmpa: assert property (p_cmpa) else $error("compare high wrong");

  property p_capture;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    (OP_IN == io_space_pkg::OP_IN && IO_ADDR_IN == `A_CAP_HI)
      |=> (RDATA_OUT == $past(CAPTURE_IN[15:8]));
  endproperty
  a_capture: assert property (p_capture) else $error("capture read wrong");

  property p_unmapped;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    (OP_IN == io_space_pkg::OP_IN && IO_ADDR_IN == 6'h00) |=> (RDATA_OUT == 8'h00);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("reserved read nonzero");

  property p_bit_clear;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    (OP_IN == io_space_pkg::OP_BIT_CLEAR && IO_ADDR_IN == `A_PA_OUT)
      |=> (PA_OUT_OUT == ($past(PA_OUT_OUT) & ~(8'h01 << $past(BIT_SEL_IN))));
  endproperty
  a_bit_clear: assert property (p_bit_clear) else $error("bit clear wrong");

  property p_skip_clear;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    (OP_IN == io_space_pkg::OP_SKIP_CLEAR && IO_ADDR_IN == `A_PA_OUT)
      |=> (SKIP_OUT != $past(PA_OUT_OUT[BIT_SEL_IN]));
  endproperty
  a_skip_clear: assert property (p_skip_clear) else $error("skip clear wrong");

  // skips above the bit-addressable range must never fire
  property p_skip_high;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    ((OP_IN == io_space_pkg::OP_SKIP_SET || OP_IN == io_space_pkg::OP_SKIP_CLEAR)
      && IO_ADDR_IN >= `IO_BIT_LIMIT) |=> !SKIP_OUT;
  endproperty
  a_skip_high: assert property (p_skip_high) else $error("skip high fired");

  property p_ro_drop;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    (OP_IN == io_space_pkg::OP_OUT && IO_ADDR_IN == `A_PA_IN)
      |=> ($stable(PA_OUT_OUT) && $stable(PA_DIR_OUT));
  endproperty
  a_ro_drop: assert property (p_ro_drop) else $error("read-only write leaked");

  property p_dm_read;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    (OP_IN == io_space_pkg::OP_NONE && DM_RE_IN && DM_ADDR_IN == `IO_DATA_LAST)
      |=> (RDATA_OUT == $past(STATUS_OUT));
  endproperty
  a_dm_read: assert property (p_dm_read) else $error("alias read wrong");

  // usb registers live high in data memory and must stay out of this window
  property p_usb_out;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    (DM_ADDR_IN > `IO_DATA_LAST) |-> !DM_HIT_OUT;
  endproperty
  a_usb_out: assert property (p_usb_out) else $error("high address hit");

  property p_baud;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    (OP_IN == io_space_pkg::OP_OUT && IO_ADDR_IN == `A_SER_BAUD)
      |=> (SER_BAUD_OUT == $past(WDATA_IN));
  endproperty
  a_baud: assert property (p_baud) else $error("baud write lost");

  property p_dir;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    (OP_IN == io_space_pkg::OP_OUT && IO_ADDR_IN == `A_PA_DIR)
      |=> (PA_DIR_OUT == $past(WDATA_IN));
  endproperty
  a_dir: assert property (p_dir) else $error("direction write lost");

  // a write cycle returns no read data, so a stale byte cannot leak out
  property p_out_quiet;
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    (OP_IN == io_space_pkg::OP_OUT) |=> (RDATA_OUT == 8'h00);
  endproperty
  a_out_quiet: assert property (p_out_quiet) else $error("read data on write");

  c_out: cover property (@(posedge CLK_IN) OP_IN == io_space_pkg::OP_OUT);
  c_dm: cover property (@(posedge CLK_IN) DM_WE_IN && dm_hit && OP_IN == io_space_pkg::OP_NONE);
  c_skip: cover property (@(posedge CLK_IN) SKIP_OUT);
  c_bit_high: cover property (@(posedge CLK_IN) OP_IN == io_space_pkg::OP_BIT_SET && !bit_ok);
  c_dm_read: cover property (@(posedge CLK_IN) DM_RE_IN && dm_hit && OP_IN == io_space_pkg::OP_NONE);

endmodule
`default_nettype wire

/* dv/core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************
// core side model
// ****************
module core_model (
  input wire logic clk_in, // system clock
  input wire logic [7:0] rdata_in, // read byte
  input wire logic skip_in, // skip pulse
  output var io_space_pkg::io_op_t op_out, // operation
  output logic [5:0] addr_out, // io address
  output logic [2:0] bit_out, // bit index
  output logic [7:0] wdata_out, // write byte
  output logic we_out, // data write strobe
  output logic re_out, // data read strobe
  output logic [9:0] dm_addr_out // data address
);
  logic [7:0] rd_seen;
  logic sk_seen;
  // idle bus from time zero
  initial begin
    op_out = io_space_pkg::OP_NONE;
    addr_out = 6'h00;
    bit_out = 3'h0;
    wdata_out = 8'h00;
    we_out = 1'b0;
    re_out = 1'b0;
    dm_addr_out = 10'h000;
  end
  // one io instruction; callers only write mapped places, reserved bits low
  task io(input io_space_pkg::io_op_t o, input logic [5:0] a, input logic [2:0] b,
          input logic [7:0] d);
    @(posedge clk_in);
    #1;
    op_out = o;
    addr_out = a;
    bit_out = b;
    wdata_out = d;
    @(posedge clk_in);
    #1;
    rd_seen = rdata_in;
    sk_seen = skip_in;
    op_out = io_space_pkg::OP_NONE;
    // released lines show the inverse so stale data cannot pass
    addr_out = ~a;
    wdata_out = ~d;
  endtask
  // one data-memory access; the address stays up so the hit flag can be read
  task dm(input logic w, input logic r, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1;
    we_out = w;
    re_out = r;
    dm_addr_out = a;
    wdata_out = d;
    @(posedge clk_in);
    #1;
    rd_seen = rdata_in;
    we_out = 1'b0;
    re_out = 1'b0;
    wdata_out = ~d;
  endtask
endmodule
`default_nettype wire

/* dv/io_space_register_decoder_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************
// bench
// ****************
module io_space_register_decoder_tb;
  localparam io_space_pkg::io_op_t O_IN = io_space_pkg::OP_IN;
  localparam io_space_pkg::io_op_t O_OUT = io_space_pkg::OP_OUT;
  localparam io_space_pkg::io_op_t O_SET = io_space_pkg::OP_BIT_SET;
  localparam io_space_pkg::io_op_t O_CLR = io_space_pkg::OP_BIT_CLEAR;
  localparam io_space_pkg::io_op_t O_SKS = io_space_pkg::OP_SKIP_SET;
  localparam io_space_pkg::io_op_t O_SKC = io_space_pkg::OP_SKIP_CLEAR;
  localparam logic [5:0] RW_A [29] = '{6'h09, 6'h0A, 6'h0B, 6'h11, 6'h12, 6'h13, 6'h17,
    6'h18, 6'h1A, 6'h1B, 6'h21, 6'h28, 6'h29, 6'h2A, 6'h2B, 6'h2C, 6'h2D, 6'h2E, 6'h2F,
    6'h32, 6'h33, 6'h35, 6'h38, 6'h39, 6'h3A, 6'h3B, 6'h3D, 6'h3E, 6'h3F};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] pa = 8'h00, pb = 8'h00, pd = 8'h00, sst = 8'h00;
  logic [15:0] cap = 16'h0000;
  io_space_pkg::io_op_t op;
  logic [5:0] addr;
  logic [2:0] bsel;
  logic [7:0] wd, rdata, pa_o, pa_d, pb_o, pb_d, pc_o, pd_o, pd_d, baud, ctrl, stat;
  logic [9:0] dma;
  logic we, re, hit, skip;
  logic [15:0] cmpa, cmpb;
  int errors = 0;
  int check_count = 0;
  // 20 MHz clock
  always #25 clk = ~clk;
  io_space_register_decoder dut_u (.CLK_IN(clk), .RSTN_IN(rstn), .OP_IN(op),
    .IO_ADDR_IN(addr), .BIT_SEL_IN(bsel), .WDATA_IN(wd), .DM_WE_IN(we), .DM_RE_IN(re),
    .DM_ADDR_IN(dma), .PA_PINS_IN(pa), .PB_PINS_IN(pb), .PD_PINS_IN(pd),
    .SER_STAT_HW_IN(sst), .CAPTURE_IN(cap), .RDATA_OUT(rdata), .DM_HIT_OUT(hit),
    .SKIP_OUT(skip), .PA_OUT_OUT(pa_o), .PA_DIR_OUT(pa_d), .PB_OUT_OUT(pb_o),
    .PB_DIR_OUT(pb_d), .PC_OUT_OUT(pc_o), .PD_OUT_OUT(pd_o), .PD_DIR_OUT(pd_d),
    .SER_BAUD_OUT(baud), .SER_CTRL_OUT(ctrl), .CMPA_OUT(cmpa), .CMPB_OUT(cmpb),
    .STATUS_OUT(stat));
  core_model core_u (.clk_in(clk), .rdata_in(rdata), .skip_in(skip), .op_out(op),
    .addr_out(addr), .bit_out(bsel), .wdata_out(wd), .we_out(we), .re_out(re),
    .dm_addr_out(dma));
  // shared compare; 8-bit values widen with zeros, unknowns still fail
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task end_sim;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // every writable place: zero after reset, then write and read back
  task t_rw;
    for (int i = 0; i < 29; i++) begin
      core_u.io(O_IN, RW_A[i], 3'h0, 8'h00);
      chk("reset value", 16'h0000, core_u.rd_seen);
      core_u.io(O_OUT, RW_A[i], 3'h0, {2'b10, RW_A[i]});
      core_u.io(O_IN, RW_A[i], 3'h0, 8'h00);
      chk("readback", {2'b10, RW_A[i]}, core_u.rd_seen);
    end
    chk("port a out", 16'h009B, pa_o);
    chk("port a dir", 16'h009A, pa_d);
    chk("baud", 16'h0089, baud);
    chk("ser ctrl", 16'h008A, ctrl);
    chk("cmp a", 16'hABAA, cmpa);
    chk("cmp b", 16'hA9A8, cmpb);
    chk("port b", 16'h9897, {pb_o, pb_d});
    chk("port c d", 16'h9392, {pc_o, pd_o});
    chk("status", 16'h00BF, stat);
    chk("port d dir", 16'h0091, pd_d);
  endtask
  // bit ops touch one bit, only below 0x20; skips follow the selected bit
  task t_bits;
    core_u.io(O_SET, 6'h1B, 3'h2, 8'h00);
    chk("bit set", 16'h009F, pa_o);
    core_u.io(O_CLR, 6'h1B, 3'h7, 8'h00);
    chk("bit clear", 16'h001F, pa_o);
    core_u.io(O_SET, 6'h2A, 3'h6, 8'h00);
    chk("bit set high", 16'hABAA, cmpa);
    core_u.io(O_SET, 6'h3F, 3'h6, 8'h00);
    chk("bit set status", 16'h00BF, stat);
    core_u.io(O_SKS, 6'h1B, 3'h0, 8'h00);
    chk("skip set", 16'h0001, core_u.sk_seen);
    core_u.io(O_SKC, 6'h1B, 3'h0, 8'h00);
    chk("skip clear", 16'h0000, core_u.sk_seen);
    core_u.io(O_SKC, 6'h1B, 3'h7, 8'h00);
    chk("skip clear", 16'h0001, core_u.sk_seen);
    core_u.io(O_SKS, 6'h2A, 3'h1, 8'h00);
    chk("skip high", 16'h0000, core_u.sk_seen);
  endtask
  // data-memory alias window and the hit flag at its edges
  task t_alias;
    logic [9:0] ha [5];
    ha = '{10'h01F, 10'h020, 10'h05F, 10'h060, 10'h3FB};
    core_u.dm(1'b1, 1'b0, 10'h03B, 8'h3C);
    chk("alias write", 16'h003C, pa_o);
    chk("write rdata", 16'h0000, core_u.rd_seen);
    core_u.dm(1'b1, 1'b0, 10'h03A, 8'h5A);
    chk("alias dir", 16'h005A, pa_d);
    core_u.dm(1'b0, 1'b1, 10'h05F, 8'h00);
    chk("alias read", 16'h00BF, core_u.rd_seen);
    for (int i = 0; i < 5; i++) begin
      core_u.dm(1'b0, 1'b0, ha[i], 8'h00);
      chk("hit", {15'h0000, (i == 1 || i == 2)}, hit);
    end
  endtask
  // pins, capture and serial status seen through the read path
  task t_pins;
    logic [5:0] a [6];
    logic [7:0] e [6];
    a = '{6'h19, 6'h16, 6'h10, 6'h25, 6'h24, 6'h0B};
    e = '{8'hC3, 8'h3C, 8'h5A, 8'h12, 8'h34, 8'hCB};
    @(posedge clk);
    #1;
    pa = 8'hC3;
    pb = 8'h3C;
    pd = 8'h5A;
    sst = 8'h40;
    cap = 16'h1234;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      core_u.io(O_IN, a[i], 3'h0, 8'h00);
      chk("input read", e[i], core_u.rd_seen);
    end
    core_u.io(O_SKS, 6'h19, 3'h6, 8'h00);
    chk("pin skip", 16'h0001, core_u.sk_seen);
  endtask
  // read-only write dropped, unassigned reads zero, mid-run reset clears
  task t_refuse;
    logic [5:0] a [4];
    a = '{6'h00, 6'h1C, 6'h30, 6'h3C};
    core_u.io(O_OUT, 6'h19, 3'h0, 8'h0F);
    core_u.io(O_IN, 6'h19, 3'h0, 8'h00);
    chk("ro write", 16'h00C3, core_u.rd_seen);
    for (int i = 0; i < 4; i++) begin
      core_u.io(O_IN, a[i], 3'h0, 8'h00);
      chk("unassigned", 16'h0000, core_u.rd_seen);
    end
    chk("no side effect", 16'h003C, pa_o);
    @(posedge clk);
    #1;
    rstn = 1'b0;
    repeat (3) @(posedge clk);
    chk("reset again", 16'h0000, {pa_o, stat});
    chk("dir after reset", 16'h0000, pa_d);
    #1;
    rstn = 1'b1;
    core_u.io(O_IN, 6'h1B, 3'h0, 8'h00);
    chk("read after reset", 16'h0000, core_u.rd_seen);
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    #1;
    rstn = 1'b1;
    t_rw();
    t_bits();
    t_alias();
    t_pins();
    t_refuse();
    end_sim();
  end
  // watchdog: the tests need well under a quarter of this span
  initial begin
    #100000;
    errors++;
    end_sim();
  end
endmodule
`default_nettype wire
